// ===== hw/clockgen_pkg.sv
// constants, register layouts and types of the clock generator control block
package clockgen_pkg;

    // register offsets on the plain register port
    localparam logic [7:0] CTL_OFFSET = 8'h00;
    localparam logic [7:0] BW_OFFSET  = 8'h01;

    // values after reset; loop enable comes up set
    localparam logic [7:0] CTL_RESET = 8'h20;
    localparam logic [7:0] BW_RESET  = 8'h00;
    localparam logic [7:0] RD_IDLE   = 8'h00;

    // field positions in the loop control register
    localparam int CTL_IE_BIT    = 7;
    localparam int CTL_FLAG_BIT  = 6;
    localparam int CTL_LOOP_BIT  = 5;
    localparam int CTL_BCS_BIT   = 4;
    localparam int CTL_PRE_LSB   = 2;
    localparam int CTL_OCT_LSB   = 0;

    // field positions in the bandwidth control register
    localparam int BW_AUTO_BIT   = 7;
    localparam int BW_LOCK_BIT   = 6;
    localparam int BW_TRACK_BIT  = 5;

    // slots of the input synchroniser vector
    localparam int SYNC_OSC      = 0;
    localparam int SYNC_VCO      = 1;
    localparam int SYNC_LOCK     = 2;
    localparam int SYNC_TRACK    = 3;
    localparam int SYNC_WIDTH    = 4;

    // source edges awaited on each side of a switchover, at most three
    localparam logic [1:0] SWITCH_EDGES = 2'h2;
    localparam logic [1:0] EDGE_CNT_RESET = 2'h0;

    typedef enum logic [1:0] {SW_RUN, SW_DRAIN_OLD, SW_WAIT_NEW} switch_state_type;

    typedef struct packed {
        logic       lock_change_irq_enable;
        logic       lock_change_flag;
        logic       loop_enable;
        logic       base_clock_select;
        logic [1:0] vco_output_divider_sel;
        logic [1:0] vco_octave_sel;
    } ctl_fields_type;

    typedef struct packed {
        logic       auto_bandwidth;
        logic       lock_indicator;
        logic       tracking_select;
        logic [4:0] reserved;
    } bw_fields_type;

endpackage

// ===== hw/clock_switch.sv
// glitch-free base clock source switch with output halving
`timescale 1ns/1ps
module clock_switch
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic clk_en,
    // source selection
    input  wire logic select_vco,
    input  wire logic osc_halving_bypass,
    // synchronised source levels
    input  wire logic osc_level,
    input  wire logic vco_level,
    // result
    output logic      base_clock_out,
    output logic      switch_busy
);

    clockgen_pkg::switch_state_type state_reg;
    logic       active_vco_reg;
    logic [1:0] edge_cnt_reg;
    logic       osc_prev_reg;
    logic       vco_prev_reg;
    logic       osc_rise;
    logic       vco_rise;
    logic       old_rise;
    logic       new_rise;

    assign osc_rise    = osc_level & ~osc_prev_reg;
    assign vco_rise    = vco_level & ~vco_prev_reg;
    assign old_rise    = active_vco_reg ? vco_rise : osc_rise;
    assign new_rise    = active_vco_reg ? osc_rise : vco_rise;
    assign switch_busy = (state_reg != clockgen_pkg::SW_RUN);

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            osc_prev_reg <= 1'b0;
            vco_prev_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            osc_prev_reg <= osc_level;
            vco_prev_reg <= vco_level;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_reg      <= clockgen_pkg::SW_RUN;
            active_vco_reg <= 1'b0;
            edge_cnt_reg   <= clockgen_pkg::EDGE_CNT_RESET;
        end
        else if (clk_en)
        begin
            unique case (state_reg)
                clockgen_pkg::SW_RUN:
                    if (select_vco != active_vco_reg)
                    begin
                        state_reg    <= clockgen_pkg::SW_DRAIN_OLD;
                        edge_cnt_reg <= clockgen_pkg::EDGE_CNT_RESET;
                    end
                clockgen_pkg::SW_DRAIN_OLD:
                    if (old_rise)
                    begin
                        if (edge_cnt_reg == clockgen_pkg::SWITCH_EDGES - 2'h1)
                        begin
                            state_reg      <= clockgen_pkg::SW_WAIT_NEW;
                            edge_cnt_reg   <= clockgen_pkg::EDGE_CNT_RESET;
                        end
                        else
                            edge_cnt_reg <= edge_cnt_reg + 2'h1;
                    end
                clockgen_pkg::SW_WAIT_NEW:
                    if (new_rise)
                    begin
                        if (edge_cnt_reg == clockgen_pkg::SWITCH_EDGES - 2'h1)
                        begin
                            state_reg      <= clockgen_pkg::SW_RUN;
                            active_vco_reg <= ~active_vco_reg;
                            edge_cnt_reg   <= clockgen_pkg::EDGE_CNT_RESET;
                        end
                        else
                            edge_cnt_reg <= edge_cnt_reg + 2'h1;
                    end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            base_clock_out <= 1'b0;
        else if (clk_en && !switch_busy)
        begin
            if (!active_vco_reg && osc_halving_bypass)
                base_clock_out <= osc_level;
            else if (active_vco_reg ? vco_rise : osc_rise)
                base_clock_out <= ~base_clock_out;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_switch_stasis;
        switch_busy && clk_en |=> $stable(base_clock_out);
    endproperty
    a_switch_stasis: assert property (p_switch_stasis)
        else $error("base clock moved during switchover");

    property p_switch_start;
        clk_en && !switch_busy && (select_vco != active_vco_reg) |=> switch_busy;
    endproperty
    a_switch_start: assert property (p_switch_start)
        else $error("select change did not start switchover");

endmodule

// ===== hw/pll_clock_control.sv
// control and status registers of the loop-based clock generator
`timescale 1ns/1ps
// Overview of operation
// - irq enable writable and readable only in auto
// - lock toggle in auto sets flag; flag and enable interrupt only in auto
// - flag reads zero outside auto mode
// - loop control register read clears flag, unless a toggle sets it in the same cycle
// - loop enable cannot clear while vco selected
// - loop enable set after reset
// - select refused while loop off; reset clears
// - output held static during source switch
// - select one halves vco, zero halves oscillator
// - prescaler field locked while loop enabled
// - octave field locked while loop enabled
// - auto bandwidth bit, reset manual
// - lock indicator status in auto, zero otherwise
// - tracking status in auto, control in manual
// - manual tracking value kept across auto mode
// - base clock half duty, two sources
// - reference follows oscillator; irq from lock
// - bypass option skips oscillator halving
// - zero range multiplier disables loop, forces oscillator
module pll_clock_control
(
    // clock, reset and enable
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       clk_en,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    // analog loop side
    input  wire logic       oscillator_clock,
    input  wire logic       divided_vco_clock,
    input  wire logic       lock_detect,
    input  wire logic       loop_tracking_status,
    // configuration from other registers
    input  wire logic       osc_halving_bypass,
    input  wire logic [7:0] linear_range_multiplier,
    // loop controls
    output logic            loop_on,
    output logic      [1:0] vco_output_divider_sel,
    output logic      [1:0] vco_octave_sel,
    output logic            tracking_select,
    output logic            auto_bandwidth,
    // clocks and interrupt
    output logic            base_clock_out,
    output logic            loop_reference_clock,
    output logic            switch_busy,
    output logic            clockgen_irq
);

    logic [clockgen_pkg::SYNC_WIDTH-1:0] sync1_reg;
    logic [clockgen_pkg::SYNC_WIDTH-1:0] sync2_reg;
    logic [clockgen_pkg::SYNC_WIDTH-1:0] sync3_reg;
    logic [clockgen_pkg::SYNC_WIDTH-1:0] stable_reg;
    logic [clockgen_pkg::SYNC_WIDTH-1:0] raw_in;
    logic [clockgen_pkg::SYNC_WIDTH-1:0] agree;

    logic       irq_enable_reg;
    logic       flag_reg;
    logic       loop_enable_reg;
    logic       bcs_reg;
    logic [1:0] divider_reg;
    logic [1:0] octave_reg;
    logic       auto_reg;
    logic       track_manual_reg;
    logic       lock_prev_reg;
    logic       ref_clock_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    logic       wr_ctl;
    logic       wr_bw;
    logic       rd_ctl;
    logic       rd_bw;
    logic       range_zero;
    logic       lock_stable;
    logic       lock_toggle;
    logic       track_eff;

    clockgen_pkg::ctl_fields_type wr_ctl_fields;
    clockgen_pkg::bw_fields_type  wr_bw_fields;
    clockgen_pkg::ctl_fields_type rd_ctl_fields;
    clockgen_pkg::bw_fields_type  rd_bw_fields;

    assign wr_ctl        = clk_en && reg_write && (reg_addr == clockgen_pkg::CTL_OFFSET);
    assign wr_bw         = clk_en && reg_write && (reg_addr == clockgen_pkg::BW_OFFSET);
    assign rd_ctl        = clk_en && reg_read && (reg_addr == clockgen_pkg::CTL_OFFSET);
    assign rd_bw         = clk_en && reg_read && (reg_addr == clockgen_pkg::BW_OFFSET);
    assign wr_ctl_fields = clockgen_pkg::ctl_fields_type'(reg_wdata);
    assign wr_bw_fields  = clockgen_pkg::bw_fields_type'(reg_wdata);
    assign range_zero    = (linear_range_multiplier == 8'h00);

    assign raw_in[clockgen_pkg::SYNC_OSC]   = oscillator_clock;
    assign raw_in[clockgen_pkg::SYNC_VCO]   = divided_vco_clock;
    assign raw_in[clockgen_pkg::SYNC_LOCK]  = lock_detect;
    assign raw_in[clockgen_pkg::SYNC_TRACK] = loop_tracking_status;
    assign agree = ~(sync2_reg ^ sync3_reg);

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            sync1_reg  <= '0;
            sync2_reg  <= '0;
            sync3_reg  <= '0;
            stable_reg <= '0;
        end
        else if (clk_en)
        begin
            sync1_reg  <= raw_in;
            sync2_reg  <= sync1_reg;
            sync3_reg  <= sync2_reg;
            stable_reg <= (sync3_reg & agree) | (stable_reg & ~agree);
        end
    end

    assign lock_stable = stable_reg[clockgen_pkg::SYNC_LOCK];
    assign lock_toggle = lock_stable ^ lock_prev_reg;

    // tracking shows loop status in auto
    assign track_eff = auto_reg ? stable_reg[clockgen_pkg::SYNC_TRACK] : track_manual_reg;

    // reference is a buffered oscillator copy
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            ref_clock_reg <= 1'b0;
            lock_prev_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            ref_clock_reg <= stable_reg[clockgen_pkg::SYNC_OSC];
            lock_prev_reg <= lock_stable;
        end
    end

    // enable written only in auto mode
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            irq_enable_reg <= 1'b0;
        else if (wr_ctl && auto_reg)
            irq_enable_reg <= wr_ctl_fields.lock_change_irq_enable;
    end

    // toggle sets flag, set beats clear
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            flag_reg <= 1'b0;
        else if (clk_en && auto_reg && lock_toggle)
            flag_reg <= 1'b1;
        else if (rd_ctl)
            flag_reg <= 1'b0;
    end

    // clear refused while vco path selected
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            loop_enable_reg <= clockgen_pkg::CTL_RESET[clockgen_pkg::CTL_LOOP_BIT];
        else if (wr_ctl && (wr_ctl_fields.loop_enable || !bcs_reg))
            loop_enable_reg <= wr_ctl_fields.loop_enable;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            bcs_reg <= clockgen_pkg::CTL_RESET[clockgen_pkg::CTL_BCS_BIT];
        else if (clk_en && range_zero)
            bcs_reg <= 1'b0;
        else if (wr_ctl && (!wr_ctl_fields.base_clock_select || loop_enable_reg))
            bcs_reg <= wr_ctl_fields.base_clock_select;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            divider_reg <= clockgen_pkg::CTL_RESET[clockgen_pkg::CTL_PRE_LSB +: 2];
            octave_reg  <= clockgen_pkg::CTL_RESET[clockgen_pkg::CTL_OCT_LSB +: 2];
        end
        else if (wr_ctl && !loop_enable_reg)
        begin
            divider_reg <= wr_ctl_fields.vco_output_divider_sel;
            octave_reg  <= wr_ctl_fields.vco_octave_sel;
        end
    end

    // manual tracking value held during auto
    // lock position is write-ignored; a one written there has no effect
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            auto_reg         <= clockgen_pkg::BW_RESET[clockgen_pkg::BW_AUTO_BIT];
            track_manual_reg <= clockgen_pkg::BW_RESET[clockgen_pkg::BW_TRACK_BIT];
        end
        else if (wr_bw)
        begin
            auto_reg <= wr_bw_fields.auto_bandwidth;
            if (!auto_reg)
                track_manual_reg <= wr_bw_fields.tracking_select;
        end
    end

    always_comb
    begin
        rd_ctl_fields.lock_change_irq_enable = irq_enable_reg & auto_reg;
        rd_ctl_fields.lock_change_flag       = flag_reg & auto_reg;
        rd_ctl_fields.loop_enable            = loop_enable_reg;
        rd_ctl_fields.base_clock_select      = bcs_reg;
        rd_ctl_fields.vco_output_divider_sel = divider_reg;
        rd_ctl_fields.vco_octave_sel         = octave_reg;
        rd_bw_fields.auto_bandwidth          = auto_reg;
        rd_bw_fields.lock_indicator          = lock_stable & auto_reg;
        rd_bw_fields.tracking_select         = track_eff;
        rd_bw_fields.reserved                = '0;
        rdata_next = clockgen_pkg::RD_IDLE;
        if (rd_ctl)
            rdata_next = rd_ctl_fields;
        else if (rd_bw)
            rdata_next = rd_bw_fields;
    end

    // read data only in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            rdata_reg <= clockgen_pkg::RD_IDLE;
        else if (clk_en)
            rdata_reg <= rdata_next;
    end

    // base clock from glitch-free switch
    // a dead vco under zero range would stall the drain; lend it oscillator edges
    clock_switch u_switch
    (
        .clk_sys            (clk_sys),
        .reset              (reset),
        .clk_en             (clk_en),
        .select_vco         (bcs_reg),
        .osc_halving_bypass (osc_halving_bypass),
        .osc_level          (stable_reg[clockgen_pkg::SYNC_OSC]),
        .vco_level          (range_zero ? stable_reg[clockgen_pkg::SYNC_OSC]
                                        : stable_reg[clockgen_pkg::SYNC_VCO]),
        .base_clock_out     (base_clock_out),
        .switch_busy        (switch_busy)
    );

    assign loop_on                = loop_enable_reg & ~range_zero;
    assign vco_output_divider_sel = divider_reg;
    assign vco_octave_sel         = octave_reg;
    assign tracking_select        = track_eff;
    assign auto_bandwidth         = auto_reg;
    assign loop_reference_clock   = ref_clock_reg;
    assign reg_rdata              = rdata_reg;
    assign clockgen_irq           = flag_reg & irq_enable_reg & auto_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_lock_edge;
        clk_en && auto_reg && lock_toggle;
    endsequence

    sequence s_irq_armed;
        irq_enable_reg && auto_reg;
    endsequence

    property p_flag_sets;
        s_lock_edge |=> flag_reg;
    endproperty
    a_flag_sets: assert property (p_flag_sets)
        else $error("lock toggle did not set flag");

    property p_irq_follows;
        s_lock_edge ##0 s_irq_armed |=> clockgen_irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("armed lock toggle raised no interrupt");

    property p_read_clears;
        rd_ctl && !(auto_reg && lock_toggle) |=> !flag_reg;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("control read left flag set");

    property p_manual_reads_zero;
        rd_ctl && !auto_reg |=> (reg_rdata[clockgen_pkg::CTL_IE_BIT] == 1'b0)
            && (reg_rdata[clockgen_pkg::CTL_FLAG_BIT] == 1'b0);
    endproperty
    a_manual_reads_zero: assert property (p_manual_reads_zero)
        else $error("enable or flag read nonzero in manual mode");

    property p_lock_manual_zero;
        rd_bw && !auto_reg |=> reg_rdata[clockgen_pkg::BW_LOCK_BIT] == 1'b0;
    endproperty
    a_lock_manual_zero: assert property (p_lock_manual_zero)
        else $error("lock indicator read nonzero in manual mode");

    property p_loop_held;
        wr_ctl && bcs_reg && !wr_ctl_fields.loop_enable |=> loop_enable_reg;
    endproperty
    a_loop_held: assert property (p_loop_held)
        else $error("loop disabled while vco path selected");

    property p_select_refused;
        clk_en && !loop_enable_reg && !bcs_reg |=> !bcs_reg;
    endproperty
    a_select_refused: assert property (p_select_refused)
        else $error("select set while loop off");

    property p_fields_locked;
        wr_ctl && loop_enable_reg |=> $stable(divider_reg) && $stable(octave_reg);
    endproperty
    a_fields_locked: assert property (p_fields_locked)
        else $error("divider or octave changed while loop on");

    property p_manual_kept;
        auto_reg |=> $stable(track_manual_reg);
    endproperty
    a_manual_kept: assert property (p_manual_kept)
        else $error("stored tracking value changed in auto mode");

    property p_range_zero;
        clk_en && range_zero |=> !bcs_reg ##0 !loop_on;
    endproperty
    a_range_zero: assert property (p_range_zero)
        else $error("zero range did not force oscillator path");

    property p_reset_loop_on;
        disable iff (1'b0) $fell(reset) |-> loop_enable_reg && !bcs_reg;
    endproperty
    a_reset_loop_on: assert property (p_reset_loop_on)
        else $error("loop enable not set after reset");

endmodule

// ===== tb/loop_model.sv
// behavioural analog loop: free oscillator, vco clock gated by loop enable
`timescale 1ns/1ps
module loop_model
(
    // control
    input  wire logic loop_on,
    // clocks
    output logic      oscillator_clock,
    output logic      divided_vco_clock
);
    initial
    begin
        oscillator_clock = 1'b0;
        forever #21 oscillator_clock = ~oscillator_clock;
    end
    // vco stands still while the loop is off
    initial
    begin
        divided_vco_clock = 1'b0;
        forever
        begin
            #14;
            divided_vco_clock = loop_on ? ~divided_vco_clock : 1'b0;
        end
    end
endmodule

// ===== tb/pll_clock_control_test.sv
// register-level regression of the clock generator control block
`timescale 1ns/1ps
module pll_clock_control_test;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic osc, vco, loop_on, base, busy, irq, trk;
    logic lock_detect = 1'b0;
    logic trk_status = 1'b0;
    logic bypass = 1'b0;
    logic [7:0] range = 8'h40;
    logic [7:0] rd;
    logic held;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n;

    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    loop_model loop_model_inst (.loop_on(loop_on), .oscillator_clock(osc),
        .divided_vco_clock(vco));

    pll_clock_control pll_clock_control_inst (.clk_sys(clk_sys), .reset(reset),
        .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .oscillator_clock(osc), .divided_vco_clock(vco), .lock_detect(lock_detect),
        .loop_tracking_status(trk_status), .osc_halving_bypass(bypass),
        .linear_range_multiplier(range), .loop_on(loop_on),
        .vco_output_divider_sel(), .vco_octave_sel(), .tracking_select(trk),
        .auto_bandwidth(), .base_clock_out(base), .loop_reference_clock(),
        .switch_busy(busy), .clockgen_irq(irq));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        #1;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask

    // rising edges of the base clock over 120 cycles
    task automatic count_rises(output int c);
        logic h;
        c = 0;
        repeat (120)
        begin
            h = base;
            idle(1);
            if (h === 1'b0 && base === 1'b1)
                c++;
        end
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // hang guard, well above the expected run
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            conclude();
        end
    end

    initial
    begin
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        rd_chk(8'h00, 8'h20);
        rd_chk(8'h01, 8'h00);
        rd_chk(8'h05, 8'h00);
        count_rises(n);
        check({7'h0, (n >= 6 && n <= 8)}, 8'h01);
        // enable refused in manual, fields locked while loop runs
        wr(8'h00, 8'hAE);
        rd_chk(8'h00, 8'h20);
        rd_chk(8'h00, 8'h20);
        wr(8'h01, 8'h20);
        rd_chk(8'h01, 8'h20);
        check({7'h0, trk}, 8'h01);
        lock_detect <= 1'b1;
        idle(8);
        rd_chk(8'h00, 8'h20);
        rd_chk(8'h01, 8'h20);
        check({7'h0, irq}, 8'h00);
        $display("test manual done");
        wr(8'h00, 8'h00);
        check({7'h0, loop_on}, 8'h00);
        wr(8'h00, 8'h1E);
        rd_chk(8'h00, 8'h0E);
        wr(8'h01, 8'h00);
        wr(8'h00, 8'h2E);
        wr(8'h00, 8'h3E);
        rd_chk(8'h00, 8'h3E);
        wr(8'h00, 8'h1E);
        rd_chk(8'h00, 8'h3E);
        held = base;
        n = 0;
        while (busy === 1'b1 && n < 400)
        begin
            check({7'h0, base}, {7'h0, held});
            idle(1);
            n++;
        end
        check({7'h0, busy}, 8'h00);
        count_rises(n);
        // 28 ns vco period halved gives about 10.7 rises in 600 ns
        check({7'h0, (n >= 9 && n <= 12)}, 8'h01);
        $display("test switch done");
        wr(8'h01, 8'hA0);
        idle(6);
        rd_chk(8'h01, 8'hC0);
        check({7'h0, trk}, 8'h00);
        trk_status <= 1'b1;
        idle(6);
        rd_chk(8'h01, 8'hE0);
        check({7'h0, trk}, 8'h01);
        trk_status <= 1'b0;
        wr(8'h00, 8'hBE);
        rd_chk(8'h00, 8'hBE);
        lock_detect <= 1'b0;
        idle(8);
        check({7'h0, irq}, 8'h01);
        rd_chk(8'h00, 8'hFE);
        rd_chk(8'h00, 8'hBE);
        check({7'h0, irq}, 8'h00);
        wr(8'h01, 8'h00);
        rd_chk(8'h01, 8'h20);
        rd_chk(8'h00, 8'h3E);
        $display("test auto done");
        range <= 8'h00;
        idle(3);
        check({7'h0, loop_on}, 8'h00);
        rd_chk(8'h00, 8'h2E);
        idle(60);
        check({7'h0, busy}, 8'h00);
        bypass <= 1'b1;
        count_rises(n);
        check({7'h0, (n >= 13 && n <= 16)}, 8'h01);
        $display("test range done");
        conclude();
    end
endmodule
